//--- rtl/fpc_panel_ctrl.sv
// Functional notes
// - Step amplitude walks a 1-2-5 ladder; pulse waveform for current in high-current.
// - Offset held in 1% steps from 0% to 500% of step amplitude.
// - Step changes keep offset percentage, so absolute offset scales with it.
// - Pulsed step signal gets pulsed offset; offset amount is reported.
// - Shift makes offset steps coarse; both offset buttons zero it.
// - Divide-by-ten toggles tenfold step reduction, offset untouched, indicator lit.
// - Shift with divide-by-ten disables step output and its readout.
// - Cursor select cycles dot, sloped line and window only.
// - Dot hidden live, stored curve only in compare, off-screen axis blinks.
// - Line cursor absent live; position buttons change slope; slope, intercept reported.
// - Window usable always, base point top-right or bottom-left anchors readout.
// - Shift makes cursor position buttons move or slope faster.
// - Shift remaps save, recall, store, compare, view and enter buttons.
// - REN plus own listen address gives remote; local button returns control.
// - Shift with local button reads address and terminator switches, shows them.
// - User request raises SRQ and its indicator until serial poll acknowledges.
// - Shift with user request shows firmware version, no service request.
// - Plot button in store or view sends full plot; shift sends curve only.
// - Address 0 to 30 plots to parallel port, 31 to the bus.
// - Busy lit during plot; completion darkens it and raises SRQ.
// - Plot button during transfer aborts bus plots, not parallel ones.
// - Switch settings load once after reset, then only on shift with local button.
module fpc_panel_ctrl #(
	parameter int BLINK_HALF_CYC = fpc_pkg::BLINK_HALF_CYC
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [fpc_pkg::ADDR_W-1:0] regAddr,
	input wire logic [fpc_pkg::DATA_W-1:0] regWData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [fpc_pkg::DATA_W-1:0] regRData,
	input wire fpc_pkg::fpc_btn_t panelBtn,
	input wire logic [5:0] cfgSwitch,
	input wire logic renPin,
	input wire logic listenAddrSeen,
	input wire logic serialPollAck,
	input wire logic srqIn,
	output logic srqOut,
	output logic srqOeN,
	input wire logic plotDone,
	output fpc_pkg::fpc_act_t panelAct,
	output logic [3:0] stepIdx,
	output logic stepPulseMode,
	output logic [8:0] offsetPct,
	output logic offsetPulse,
	output logic divTenLed,
	output logic stepOutEn,
	output logic stepReadoutEn,
	output fpc_pkg::fpc_cursor_t cursorType,
	output logic cursorVisible,
	output logic cursorStoredOnly,
	output logic blinkVert,
	output logic blinkHoriz,
	output logic remoteLed,
	output logic srqLed,
	output logic busyLed,
	output logic showAddr,
	output logic showVersion,
	output logic plotStart,
	output logic plotAbort,
	output logic plotToBus,
	output logic plotCurveOnly
);
	localparam logic [fpc_pkg::BLINK_W-1:0] BLINK_LAST = fpc_pkg::BLINK_W'(BLINK_HALF_CYC - 1);

	typedef struct packed {
		fpc_pkg::fpc_btn_t b1;
		fpc_pkg::fpc_btn_t b2;
		fpc_pkg::fpc_btn_t b3;
		logic [1:0] renS;
		logic [1:0] srqS;
		logic [5:0] sw1;
		logic [5:0] sw2;
		logic [1:0] swFill;
		logic swLoaded;
		logic [4:0] busAddr;
		logic term;
		fpc_pkg::fpc_disp_t disp;
		logic hv;
		logic volt;
		logic [3:0] step;
		logic pulseMode;
		logic [8:0] ofs;
		logic divTen;
		logic stepDis;
		fpc_pkg::fpc_cursor_t cur;
		logic winTop;
		logic [11:0] x;
		logic [11:0] y;
		logic [11:0] slope;
		logic [11:0] icpt;
		logic visible;
		logic storedOnly;
		logic [fpc_pkg::BLINK_W-1:0] blinkCnt;
		logic blinkPh;
		logic blinkV;
		logic blinkH;
		logic remote;
		logic srq;
		fpc_pkg::fpc_plot_t plot;
		logic toBus;
		logic curveOnly;
		fpc_pkg::fpc_act_t act;
		logic showAddr;
		logic showVer;
		logic plotStart;
		logic plotAbort;
		logic [fpc_pkg::DATA_W-1:0] rdData;
	} fpc_state_t;

	fpc_state_t s;
	fpc_state_t next_s;

	// Next-state logic for the whole panel controller
	always_comb
	begin
		fpc_pkg::fpc_btn_t raw;
		fpc_pkg::fpc_btn_t e;
		logic sh;
		logic ren;
		logic srqSet;
		logic [3:0] stepMax;
		logic [8:0] ofsInc;
		logic [11:0] d;
		logic [12:0] sum;
		logic [23:0] prod;
		raw = fpc_pkg::fpc_btn_t'(s.b2 & ~s.b3);
		e = raw;
		sh = s.b2.shift;
		ren = s.renS[1];
		srqSet = 1'b0;
		stepMax = 4'h0;
		ofsInc = 9'h000;
		d = 12'h000;
		sum = 13'h0000;
		prod = 24'h000000;
		next_s = s;
		// Two-flop synchronisers, then one more stage for press edges
		next_s.b1 = panelBtn;
		next_s.b2 = s.b1;
		next_s.b3 = s.b2;
		next_s.renS = {s.renS[0], renPin};
		next_s.srqS = {s.srqS[0], srqIn};
		next_s.sw1 = cfgSwitch;
		next_s.sw2 = s.sw1;
		next_s.swFill = {s.swFill[0], 1'b1};
		next_s.act = '0;
		next_s.showAddr = 1'b0;
		next_s.showVer = 1'b0;
		next_s.plotStart = 1'b0;
		next_s.plotAbort = 1'b0;
		next_s.rdData = '0;

		// Front panel is locked out in remote except the local button
		if (s.remote)
		begin
			e = '0;
			e.localBtn = raw.localBtn;
		end

		// Remote entry and exit
		if (!ren)
			next_s.remote = 1'b0;
		else if (listenAddrSeen)
			next_s.remote = 1'b1;
		if (e.localBtn && !sh)
			next_s.remote = 1'b0;

		// Switch bank is caught once the sync stages hold real levels, then only on shifted local
		if ((s.swFill[1] && !s.swLoaded) || (e.localBtn && sh))
		begin
			next_s.busAddr = s.sw2[4:0];
			next_s.term = s.sw2[5];
			next_s.swLoaded = 1'b1;
			next_s.showAddr = s.swLoaded;
		end

		// Step amplitude ladder; range depends on the source type only
		stepMax = s.volt ? fpc_pkg::STEP_MAX_VOLT : fpc_pkg::STEP_MAX_CUR;
		if (e.stepUp && s.step < stepMax)
			next_s.step = s.step + 4'h1;
		else if (e.stepDn && s.step != 4'h0)
			next_s.step = s.step - 4'h1;
		if (next_s.step > stepMax)
			next_s.step = stepMax;
		// Offset stays a percentage, so it follows the step amplitude
		next_s.pulseMode = !s.volt && !s.hv;

		// Offset buttons: both together zero, shift coarse, clamp at limits
		ofsInc = sh ? fpc_pkg::OFS_COARSE : fpc_pkg::OFS_FINE;
		if ((e.ofsUp && s.b2.ofsDn) || (e.ofsDn && s.b2.ofsUp))
			next_s.ofs = 9'h000;
		else if (e.ofsUp)
		begin
			if (s.ofs > fpc_pkg::OFS_MAX - ofsInc)
				next_s.ofs = fpc_pkg::OFS_MAX;
			else
				next_s.ofs = s.ofs + ofsInc;
		end
		else if (e.ofsDn)
		begin
			if (s.ofs < ofsInc)
				next_s.ofs = 9'h000;
			else
				next_s.ofs = s.ofs - ofsInc;
		end

		// Divide-by-ten and its shifted disable both toggle
		if (e.divTen && sh)
			next_s.stepDis = !s.stepDis;
		else if (e.divTen)
			next_s.divTen = !s.divTen;

		// Cursor type selection, line skipped while live
		if (e.curSelUp)
		begin
			case (s.cur)
				fpc_pkg::CUR_DOT: next_s.cur = (s.disp == fpc_pkg::DISP_NONSTORE) ?
					fpc_pkg::CUR_WINDOW : fpc_pkg::CUR_LINE;
				fpc_pkg::CUR_LINE: next_s.cur = fpc_pkg::CUR_WINDOW;
				default: next_s.cur = fpc_pkg::CUR_DOT;
			endcase
		end
		else if (e.curSelDn)
		begin
			case (s.cur)
				fpc_pkg::CUR_DOT: next_s.cur = fpc_pkg::CUR_WINDOW;
				fpc_pkg::CUR_WINDOW: next_s.cur = (s.disp == fpc_pkg::DISP_NONSTORE) ?
					fpc_pkg::CUR_DOT : fpc_pkg::CUR_LINE;
				default: next_s.cur = fpc_pkg::CUR_DOT;
			endcase
		end
		if (next_s.cur == fpc_pkg::CUR_LINE && s.disp == fpc_pkg::DISP_NONSTORE)
			next_s.cur = fpc_pkg::CUR_DOT;
		if (e.winBase)
			next_s.winTop = !s.winTop;

		// Position buttons: slope for the line, saturating move otherwise
		d = sh ? fpc_pkg::CUR_FAST : fpc_pkg::CUR_SLOW;
		if (s.cur == fpc_pkg::CUR_LINE)
		begin
			if (e.curUp || e.curRight)
			begin
				sum = {1'b0, s.slope} + {1'b0, d};
				next_s.slope = sum[12] ? fpc_pkg::POS_MAX : sum[11:0];
			end
			else if (e.curDown || e.curLeft)
				next_s.slope = (s.slope < d) ? 12'h000 : s.slope - d;
		end
		else
		begin
			// Point moved is the dot, or the window's base corner
			if (e.curRight)
			begin
				sum = {1'b0, s.x} + {1'b0, d};
				next_s.x = sum[12] ? fpc_pkg::POS_MAX : sum[11:0];
			end
			else if (e.curLeft)
				next_s.x = (s.x < d) ? 12'h000 : s.x - d;
			if (e.curUp)
			begin
				sum = {1'b0, s.y} + {1'b0, d};
				next_s.y = sum[12] ? fpc_pkg::POS_MAX : sum[11:0];
			end
			else if (e.curDown)
				next_s.y = (s.y < d) ? 12'h000 : s.y - d;
		end
		// Horizontal intercept; slope is kept as inverse gradient in 1/16 units
		prod = s.y * s.slope;
		next_s.icpt = s.x - prod[15:4];

		// Visibility by display mode; the window shows everywhere
		case (s.cur)
			fpc_pkg::CUR_WINDOW: next_s.visible = 1'b1;
			default: next_s.visible = (s.disp != fpc_pkg::DISP_NONSTORE);
		endcase
		next_s.storedOnly = (s.disp == fpc_pkg::DISP_COMPARE) &&
			(s.cur != fpc_pkg::CUR_WINDOW);

		// Blink phase from a free divider, shared by both readout halves
		if (s.blinkCnt >= BLINK_LAST)
		begin
			next_s.blinkCnt = '0;
			next_s.blinkPh = !s.blinkPh;
		end
		else
			next_s.blinkCnt = s.blinkCnt + 1'b1;
		next_s.blinkV = (s.cur == fpc_pkg::CUR_DOT) && s.visible &&
			(s.y > fpc_pkg::SCREEN_MAX) && s.blinkPh;
		next_s.blinkH = (s.cur == fpc_pkg::CUR_DOT) && s.visible &&
			(s.x > fpc_pkg::SCREEN_MAX) && s.blinkPh;

		// Shifted functions of the storage and display buttons
		next_s.act.save = e.save && !sh;
		next_s.act.erase = e.save && sh;
		next_s.act.recall = e.recall && !sh;
		next_s.act.plotDir = e.recall && sh;
		next_s.act.store = e.store && !sh;
		next_s.act.calFull = e.store && sh;
		next_s.act.compare = e.compare && !sh;
		next_s.act.calOff = e.compare && sh;
		next_s.act.view = e.view && !sh;
		next_s.act.calZero = e.view && sh;
		next_s.act.enter = e.enter && !sh;
		next_s.act.textEdit = e.enter && sh;

		// User request, or version display when shifted
		if (e.userReq && sh)
			next_s.showVer = 1'b1;
		else if (e.userReq)
			srqSet = 1'b1;

		// Plot sequencer; the parallel port cannot be stopped once started
		case (s.plot)
			fpc_pkg::PLOT_IDLE:
			begin
				if (e.plotAll && (s.disp == fpc_pkg::DISP_STORE ||
					s.disp == fpc_pkg::DISP_VIEW))
				begin
					next_s.plotStart = 1'b1;
					next_s.curveOnly = sh;
					next_s.toBus = (s.busAddr == fpc_pkg::PLOT_BUS_ADDR);
					next_s.plot = (s.busAddr == fpc_pkg::PLOT_BUS_ADDR) ?
						fpc_pkg::PLOT_BUS : fpc_pkg::PLOT_PAR;
				end
			end
			fpc_pkg::PLOT_PAR:
			begin
				if (plotDone)
				begin
					next_s.plot = fpc_pkg::PLOT_IDLE;
					srqSet = 1'b1;
				end
			end
			fpc_pkg::PLOT_BUS:
			begin
				if (plotDone)
				begin
					next_s.plot = fpc_pkg::PLOT_IDLE;
					srqSet = 1'b1;
				end
				else if (e.plotAll)
				begin
					next_s.plotAbort = 1'b1;
					next_s.plot = fpc_pkg::PLOT_IDLE;
				end
			end
			default: next_s.plot = fpc_pkg::PLOT_IDLE;
		endcase

		// A request landing with the poll acknowledge is kept
		next_s.srq = (s.srq && !serialPollAck) || srqSet;

		// Register writes steer display mode and output configuration
		if (regWr && regAddr == fpc_pkg::REG_CONFIG)
		begin
			next_s.disp = fpc_pkg::fpc_disp_t'(regWData[fpc_pkg::CFG_DISP_LSB +: 2]);
			next_s.hv = regWData[fpc_pkg::CFG_HV_BIT];
			next_s.volt = regWData[fpc_pkg::CFG_VOLT_BIT];
		end

		// Read data stand only in the cycle after the strobe
		if (regRd)
		begin
			case (regAddr)
				fpc_pkg::REG_CONFIG: next_s.rdData = {28'h0000000, s.volt, s.hv, s.disp};
				fpc_pkg::REG_STEP: next_s.rdData = {16'h0000, s.stepDis, s.divTen,
					s.pulseMode, s.ofs, s.step};
				fpc_pkg::REG_CURSOR: next_s.rdData = {4'h0, s.y, s.x, 1'b0, s.winTop,
					s.cur};
				fpc_pkg::REG_LINE: next_s.rdData = {8'h00, s.icpt, s.slope};
				fpc_pkg::REG_BUS: next_s.rdData = {12'h000, fpc_pkg::FW_VERSION,
					s.plot != fpc_pkg::PLOT_IDLE, s.srqS[1], s.srq, s.remote, 1'b0,
					s.term, 1'b0, s.busAddr};
				default: next_s.rdData = '0;
			endcase
		end
	end

	// State register
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s <= '0;
			s.slope <= fpc_pkg::SLOPE_RESET;
		end
		else
			s <= next_s;
	end

	// Outputs straight from state; the SRQ line only ever pulls low
	assign regRData = s.rdData;
	assign srqOut = 1'b0;
	assign srqOeN = !s.srq;
	assign panelAct = s.act;
	assign stepIdx = s.step;
	assign stepPulseMode = s.pulseMode;
	assign offsetPct = s.ofs;
	assign offsetPulse = s.pulseMode;
	assign divTenLed = s.divTen;
	assign stepOutEn = !s.stepDis;
	assign stepReadoutEn = !s.stepDis;
	assign cursorType = s.cur;
	assign cursorVisible = s.visible;
	assign cursorStoredOnly = s.storedOnly;
	assign blinkVert = s.blinkV;
	assign blinkHoriz = s.blinkH;
	assign remoteLed = s.remote;
	assign srqLed = s.srq;
	assign busyLed = (s.plot != fpc_pkg::PLOT_IDLE);
	assign showAddr = s.showAddr;
	assign showVersion = s.showVer;
	assign plotStart = s.plotStart;
	assign plotAbort = s.plotAbort;
	assign plotToBus = s.toBus;
	assign plotCurveOnly = s.curveOnly;
endmodule : fpc_panel_ctrl

//--- rtl/fpc_pkg.sv
package fpc_pkg;
	// Register bus shape
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam logic [4:0] REG_CONFIG = 5'h00;
	localparam logic [4:0] REG_STEP = 5'h04;
	localparam logic [4:0] REG_CURSOR = 5'h08;
	localparam logic [4:0] REG_LINE = 5'h0C;
	localparam logic [4:0] REG_BUS = 5'h10;
	// CONFIG field positions
	localparam int CFG_DISP_LSB = 0;
	localparam int CFG_HV_BIT = 2;
	localparam int CFG_VOLT_BIT = 3;
	// Step amplitude index ranges, 1-2-5 sequence from the lowest setting
	localparam logic [3:0] STEP_MAX_CUR = 4'hA;
	localparam logic [3:0] STEP_MAX_VOLT = 4'h4;
	// Offset in percent of step amplitude
	localparam logic [8:0] OFS_MAX = 9'h1F4;
	localparam logic [8:0] OFS_FINE = 9'h001;
	localparam logic [8:0] OFS_COARSE = 9'h00A;
	// Cursor geometry
	localparam logic [11:0] CUR_SLOW = 12'h001;
	localparam logic [11:0] CUR_FAST = 12'h008;
	localparam logic [11:0] SCREEN_MAX = 12'h3FF;
	localparam logic [11:0] POS_MAX = 12'hFFF;
	localparam logic [11:0] SLOPE_RESET = 12'h010;
	// Plot routing
	localparam logic [4:0] PLOT_BUS_ADDR = 5'h1F;
	// Blink timing
	localparam int CLK_HZ = 100000000;
	localparam int BLINK_HALF_MS = 250;
	localparam int BLINK_HALF_CYC = BLINK_HALF_MS * (CLK_HZ / 1000);
	localparam int BLINK_W = 25;
	// Version code shown on request; value is arbitrary
	localparam logic [7:0] FW_VERSION = 8'h11;

	typedef enum logic [1:0] {DISP_NONSTORE, DISP_STORE, DISP_COMPARE, DISP_VIEW} fpc_disp_t;
	typedef enum logic [1:0] {CUR_DOT, CUR_LINE, CUR_WINDOW} fpc_cursor_t;
	typedef enum logic [1:0] {PLOT_IDLE, PLOT_PAR, PLOT_BUS} fpc_plot_t;

	// Front-panel buttons, level high while pressed
	typedef struct packed {
		logic shift;
		logic stepUp;
		logic stepDn;
		logic ofsUp;
		logic ofsDn;
		logic divTen;
		logic curSelUp;
		logic curSelDn;
		logic curLeft;
		logic curRight;
		logic curUp;
		logic curDown;
		logic winBase;
		logic save;
		logic recall;
		logic store;
		logic compare;
		logic view;
		logic enter;
		logic localBtn;
		logic userReq;
		logic plotAll;
	} fpc_btn_t;

	// One-cycle action pulses toward storage and display logic
	typedef struct packed {
		logic save;
		logic erase;
		logic recall;
		logic plotDir;
		logic store;
		logic calFull;
		logic compare;
		logic calOff;
		logic view;
		logic calZero;
		logic enter;
		logic textEdit;
	} fpc_act_t;
endpackage : fpc_pkg

//--- verification/fpc_bus_partner.sv
module fpc_bus_partner (
	input wire logic ref_clk,
	input wire logic goRemote,
	input wire logic pollEn,
	input wire logic srqOeN,
	input wire logic plotStart,
	input wire logic plotAbort,
	output logic renPin,
	output logic listenAddrSeen,
	output logic serialPollAck,
	output logic plotDone,
	output logic srqIn
);
	timeunit 1ns;
	timeprecision 1ps;
	int sc = 0;
	int pc = 0;
	int rc = 0;
	initial {renPin, listenAddrSeen, serialPollAck, plotDone} = '0;
	// Pulled-up wire: reads high once the device lets go
	assign srqIn = srqOeN;
	// Controller: addresses only after REN, polls only a raised request
	always @(posedge ref_clk)
	begin
		renPin <= goRemote;
		// Address only once REN has had time to pass the device's synchroniser
		rc <= renPin ? rc + 1 : 0;
		listenAddrSeen <= (rc == 4);
		sc <= (!srqOeN && pollEn) ? sc + 1 : 0;
		serialPollAck <= (sc == 5);
		pc <= plotStart ? 100 : (plotAbort ? 0 : (pc > 0 ? pc - 1 : 0));
		plotDone <= (pc == 1);
	end
endmodule : fpc_bus_partner

//--- verification/fpc_panel_props.sv
module fpc_panel_props #(
	parameter int BLINK_HALF_CYC = 4
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic regRd,
	input wire logic [fpc_pkg::DATA_W-1:0] regRData,
	input wire fpc_pkg::fpc_act_t panelAct,
	input wire logic [3:0] stepIdx,
	input wire logic stepPulseMode,
	input wire logic [8:0] offsetPct,
	input wire logic offsetPulse,
	input wire logic divTenLed,
	input wire fpc_pkg::fpc_cursor_t cursorType,
	input wire logic srqLed,
	input wire logic srqOeN,
	input wire logic busyLed,
	input wire logic plotStart,
	input wire logic plotAbort,
	input wire logic plotToBus,
	input wire logic remoteLed,
	input wire logic showVersion
);
	timeunit 1ns;
	timeprecision 1ps;
	// One clock domain, so one clocking and one disable for all
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	ofs_range_a: assert property (offsetPct <= 9'h1F4) else $error("offset above limit");
	// Saturation may land short of a full step, hence the two limit values
	ofs_step_a: assert property ($changed(offsetPct) |-> (offsetPct inside {9'h000, 9'h1F4})
		|| ((offsetPct - $past(offsetPct)) inside {9'h001, 9'h00A, 9'h1FF, 9'h1F6}))
		else $error("offset moved by an odd amount");
	step_keeps_ofs_a: assert property ($changed(stepIdx) |-> $stable(offsetPct))
		else $error("offset percent moved with step");
	pulse_ofs_a: assert property (offsetPulse == stepPulseMode) else $error("offset pulse mismatch");
	div_keeps_ofs_a: assert property ($changed(divTenLed) |-> $stable(offsetPct))
		else $error("divide toggle moved offset");
	cursor_kind_a: assert property (cursorType != 2'h3) else $error("fourth cursor type");
	act_single_a: assert property ($onehot0(panelAct)) else $error("two actions at once");
	srq_lamp_a: assert property (srqLed == !srqOeN) else $error("lamp and SRQ disagree");
	plot_busy_a: assert property (plotStart |-> busyLed) else $error("plot without busy");
	abort_bus_a: assert property (plotAbort |-> plotToBus && !busyLed)
		else $error("abort on parallel plot");
	read_stands_a: assert property (!$past(regRd) |-> regRData == '0) else $error("stale read data");

	cover property (plotAbort);
	cover property ($rose(remoteLed));
	cover property (showVersion);
endmodule : fpc_panel_props

bind fpc_panel_ctrl fpc_panel_props #(.BLINK_HALF_CYC(BLINK_HALF_CYC)) fpc_panel_props_inst (
	.ref_clk, .nrst, .regRd, .regRData, .panelAct, .stepIdx, .stepPulseMode, .offsetPct,
	.offsetPulse, .divTenLed, .cursorType, .srqLed, .srqOeN, .busyLed, .plotStart, .plotAbort,
	.plotToBus, .remoteLed, .showVersion);

//--- verification/front_panel_step_cursor_gpib_control_tb.sv
module front_panel_step_cursor_gpib_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 0, nrst = 0, regWr = 0, regRd = 0, goRemote = 0, pollEn = 0;
	logic [4:0] regAddr = '0, addr;
	logic [31:0] regWData = '0, regRData, d;
	fpc_pkg::fpc_btn_t panelBtn = '0;
	logic [5:0] cfgSwitch;
	logic renPin, listenAddrSeen, serialPollAck, srqIn, srqOut, srqOeN, plotDone;
	fpc_pkg::fpc_act_t panelAct;
	logic [3:0] stepIdx;
	logic [8:0] offsetPct;
	fpc_pkg::fpc_cursor_t cursorType;
	logic stepPulseMode, offsetPulse, divTenLed, stepOutEn, stepReadoutEn, cursorVisible;
	logic cursorStoredOnly, blinkVert, blinkHoriz, remoteLed, srqLed, busyLed, showAddr;
	logic showVersion, plotStart, plotAbort, plotToBus, plotCurveOnly;
	logic [15:0] seen = '0;
	int num_errors = 0, cmp_count = 0, cyc = 0, ofs = 0, stp = 0, n;

	fpc_panel_ctrl #(.BLINK_HALF_CYC(4)) fpc_panel_ctrl_inst (.*);
	fpc_bus_partner fpc_bus_partner_inst (.*);

	always #5 ref_clk = ~ref_clk;
	// Pulses are collected so checks need not hit their single cycle
	always @(posedge ref_clk) seen <= seen | {panelAct, showAddr, showVersion, plotStart, plotAbort};
	// A hung handshake must still reach the verdict
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			complete_run();
		end
	end

	function automatic fpc_pkg::fpc_btn_t b(input int k);
		return fpc_pkg::fpc_btn_t'(22'h1 << k);
	endfunction : b
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		#1;
		cmp_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		regAddr <= a;
		regWData <= v;
		regWr <= 1;
		@(posedge ref_clk);
		regWr <= 0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [4:0] a);
		@(posedge ref_clk);
		regAddr <= a;
		regRd <= 1;
		@(posedge ref_clk);
		regRd <= 0;
		#1 d = regRData;
	endtask : rd
	task automatic hold(input fpc_pkg::fpc_btn_t v, input int k);
		@(posedge ref_clk);
		panelBtn <= v;
		repeat (k) @(posedge ref_clk);
		#1;
	endtask : hold
	// Long enough for the two-flop sync and the edge detect
	task automatic press(input fpc_pkg::fpc_btn_t v);
		hold(v, 6);
		hold('0, 6);
	endtask : press
	task complete_run;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run

	initial
	begin
		void'($urandom(32'h1523));
		addr = 5'($urandom % 31);
		cfgSwitch = {1'($urandom), addr};
		n = 50 + $urandom % 10;
		repeat (2) @(posedge ref_clk);
		nrst <= 1;
		chk({stepOutEn, stepReadoutEn, srqOeN, offsetPct}, 12'hE00);
		// Switch bank lands on the third edge after release
		repeat (4) @(posedge ref_clk);
		rd(fpc_pkg::REG_BUS);
		chk({d[6], d[4:0]}, cfgSwitch);
		// Coarse steps past the top saturate
		for (int i = 0; i < n; i++)
		begin
			press(b(21) | b(18));
			ofs = (ofs + 10 > 500) ? 500 : ofs + 10;
			chk(offsetPct, ofs);
		end
		press(b(17));
		chk(offsetPct, ofs - 1);
		hold(b(18), 6);
		press(b(18) | b(17));
		chk(offsetPct, 0);
		press(b(17));
		chk(offsetPct, 0);
		repeat (3) press(b(18));
		for (int i = 0; i < 12; i++)
		begin
			press(b(20));
			stp = (stp < 10) ? stp + 1 : 10;
			chk({stepIdx, offsetPct}, {stp[3:0], 9'h003});
		end
		rd(fpc_pkg::REG_STEP);
		chk(d[12:0], {9'h003, stp[3:0]});
		press(b(16));
		chk({divTenLed, offsetPct}, 10'h203);
		press(b(16));
		chk(divTenLed, 0);
		press(b(21) | b(16));
		chk({stepOutEn, stepReadoutEn}, 0);
		wr(fpc_pkg::REG_CONFIG, 1);
		rd(5'h14);
		chk(d, 0);
		for (int i = 0; i < 4; i++)
		begin
			press(b(15));
			chk(cursorType, (i + 1) % 3);
		end
		// Line cursor: position buttons turn the slope, shift turns it faster
		press(b(11));
		press(b(21) | b(12));
		rd(fpc_pkg::REG_LINE);
		chk(d, 32'h0000_0019);
		// Window base corner moves and is flipped to the top right
		press(b(15));
		press(b(21) | b(11));
		press(b(12));
		press(b(9));
		rd(fpc_pkg::REG_CURSOR);
		chk(d, 32'h0008_0016);
		press(b(15));
		chk({cursorType, cursorVisible, cursorStoredOnly}, 4'h2);
		// Dot pushed past the right edge makes only the horizontal part blink
		repeat (128) press(b(21) | b(12));
		hold('0, 1);
		n = blinkHoriz;
		hold('0, 3);
		chk({n[0] ^ blinkHoriz, blinkVert}, 2'h2);
		wr(fpc_pkg::REG_CONFIG, 2);
		hold('0, 2);
		chk({cursorVisible, cursorStoredOnly}, 2'h3);
		// Live mode with a voltage source: range shrinks, no pulsing
		wr(fpc_pkg::REG_CONFIG, 8);
		hold('0, 2);
		chk({cursorType, cursorVisible, stepIdx, stepPulseMode, offsetPulse}, 9'h010);
		press(b(15));
		chk({cursorType, cursorVisible}, 3'h5);
		press(b(14));
		chk(cursorType, 0);
		for (int i = 0; i < 6; i++) press(b(21) | b(8 - i));
		chk(seen[15:4], 12'h555);
		for (int i = 0; i < 6; i++) press(b(8 - i));
		chk(seen[15:4], 12'hFFF);
		goRemote <= 1;
		repeat (8) @(posedge ref_clk);
		chk(remoteLed, 1);
		press(b(18));
		chk(offsetPct, 3);
		press(b(2));
		chk(remoteLed, 0);
		goRemote <= 0;
		press(b(1));
		chk({srqLed, srqOeN}, 2'h2);
		pollEn <= 1;
		repeat (10) @(posedge ref_clk);
		chk(srqLed, 0);
		press(b(21) | b(1));
		chk({srqLed, seen[2]}, 2'h1);
		pollEn <= 0;
		wr(fpc_pkg::REG_CONFIG, 1);
		press(b(0));
		chk({busyLed, plotToBus, plotCurveOnly, seen[1]}, 4'h9);
		press(b(0));
		chk(busyLed, 1);
		repeat (100) @(posedge ref_clk);
		chk({busyLed, srqLed}, 2'h1);
		pollEn <= 1;
		repeat (10) @(posedge ref_clk);
		pollEn <= 0;
		cfgSwitch <= {cfgSwitch[5], 5'h1F};
		rd(fpc_pkg::REG_BUS);
		chk(d[4:0], addr);
		press(b(21) | b(2));
		rd(fpc_pkg::REG_BUS);
		chk({d[4:0], seen[3]}, 6'h3F);
		press(b(21) | b(0));
		chk({busyLed, plotToBus, plotCurveOnly}, 3'h7);
		press(b(0));
		chk({busyLed, seen[0], srqLed}, 3'h2);
		complete_run();
	end
endmodule : front_panel_step_cursor_gpib_control_tb
